// ### rtl/dmsd_datapath.sv
// Multiply-subtract and multiply datapath with APB register access
`timescale 1ns/1ns
`default_nettype none
module dmsd_datapath import dmsd_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Instruction decode
    input wire logic instr_valid,
    input wire dmsd_op_t instr_op,
    input wire dmsd_move_t instr_move,
    input wire logic instr_mac,
    input wire logic instr_x,
    input wire logic instr_y,
    input wire logic instr_xptr,
    input wire logic [2:0] instr_dest,
    input wire dmsd_src_t instr_src,
    input wire logic instr_src_mac,
    // X data memory
    output logic [AW-1:0] xmem_addr,
    output logic xmem_re,
    input wire logic [DW-1:0] xmem_rdata,
    // Y data memory
    output logic [AW-1:0] ymem_addr,
    output logic ymem_re,
    input wire logic [DW-1:0] ymem_rdata,
    // Flags
    output logic [1:0] guard_overflow_flag,
    output logic sticky_guard_overflow,
    output logic zero_flag,
    output logic overflow_flag,
    output logic negative_flag
);

    // =========================================================
    // State
    logic [DW-1:0] x_operand_reg_q [2];
    logic [DW-1:0] y_operand_reg_q [2];
    logic [PW-1:0] p_q;
    logic [MW-1:0] mac_accumulator_q [2];
    logic [DW-1:0] general_accumulator_q [4];
    logic [1:0] vm_q;
    logic mv_q;
    logic z_q;
    logic v_q;
    logic n_q;
    logic [AW-1:0] ptr_q [3];
    logic [AW-1:0] step_q [3];
    logic [31:0] prdata_q;
    logic pslverr_q;

    // =========================================================
    // Decode
    logic is_msb;
    logic one_mv;
    logic two_mv;
    logic dest_a;
    logic dest_y;
    logic x_use;
    logic y_use;
    logic [2:0] adv;

    assign is_msb = instr_valid && (instr_op == multiply_subtract_op);
    assign one_mv = instr_valid && (instr_move == mv_one);
    assign two_mv = instr_valid && (instr_move == mv_two);
    assign dest_a = !instr_dest[2];
    assign dest_y = instr_dest[2] && instr_dest[1];
    assign x_use = two_mv || (one_mv && instr_src == src_memory && !dest_y);
    assign y_use = two_mv || (one_mv && instr_src == src_memory && dest_y);

    // =========================================================
    // Arithmetic on pre-instruction values
    logic [DW-1:0] x_sel;
    logic [DW-1:0] y_sel;
    logic signed [PW-1:0] prod;
    logic [MW-1:0] ma_sel;
    logic [MW:0] diff;
    logic vm_d;
    logic mv_ovf;

    assign x_sel = x_operand_reg_q[instr_x];
    assign y_sel = y_operand_reg_q[instr_y];
    assign prod = $signed(x_sel) * $signed(y_sel);
    assign ma_sel = mac_accumulator_q[instr_mac];
    assign diff = {ma_sel[MW-1], ma_sel} - {{5{p_q[PW-1]}}, p_q};
    assign vm_d = !(&diff[MW-1:GB_LSB] || !(|diff[MW-1:GB_LSB]));
    assign mv_ovf = diff[MW] ^ diff[MW-1];

    // =========================================================
    // Move source
    logic [MW-1:0] src_ma;
    logic [DW-1:0] src_hi;
    logic src_gov;
    logic [DW-1:0] mv_val;
    logic mv_vflag;

    assign src_ma = mac_accumulator_q[instr_src_mac];
    assign src_hi = src_ma[GB_LSB:HI_LSB];
    assign src_gov = !(&src_ma[MW-1:GB_LSB] || !(|src_ma[MW-1:GB_LSB]));

    always_comb begin
        mv_val = src_hi;
        mv_vflag = src_gov;
        unique case (instr_src)
            src_accum_high: begin
                mv_val = src_hi;
            end
            accum_high_shift_right: begin
                mv_val = {src_hi[DW-1], src_hi[DW-1:1]};
            end
            accum_high_shift_left: begin
                mv_val = {src_hi[DW-2:0], 1'b0};
                mv_vflag = src_gov || (src_hi[DW-1] ^ src_hi[DW-2]);
            end
            src_memory: begin
                mv_val = dest_y ? ymem_rdata : xmem_rdata;
                mv_vflag = 1'b0;
            end
        endcase
    end

    // =========================================================
    // Memory ports and pointers
    assign xmem_addr = instr_xptr ? ptr_q[1] : ptr_q[0];
    assign ymem_addr = ptr_q[2];
    assign xmem_re = x_use;
    assign ymem_re = y_use;
    assign adv[0] = x_use && !instr_xptr;
    assign adv[1] = x_use && instr_xptr;
    assign adv[2] = y_use;

    // =========================================================
    // APB slave
    logic apb_wr;
    logic mv_clr;
    logic [7:0] ptr_ofs [3];

    assign apb_wr = psel && penable && pwrite;
    assign mv_clr = apb_wr && paddr == OFS_FLAGS && pwdata[FLG_MV];
    assign ptr_ofs[0] = OFS_PTR0;
    assign ptr_ofs[1] = OFS_PTR1;
    assign ptr_ofs[2] = OFS_PTR3;
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    for (genvar g = 0; g < 3; g++) begin : g_ptr
        dmsd_ptr u_ptr (
            .clk(clk),
            .nrst(nrst),
            .wr(apb_wr && paddr == ptr_ofs[g]),
            .wr_addr(pwdata[AW-1:0]),
            .wr_step(pwdata[PTR_STEP_LSB+AW-1:PTR_STEP_LSB]),
            .adv(adv[g]),
            .addr_q(ptr_q[g]),
            .step_q(step_q[g])
        );
    end

    logic [31:0] rd_val;
    logic rd_err;

    always_comb begin
        rd_val = '0;
        rd_err = 1'b0;
        unique case (paddr)
            OFS_FLAGS: begin
                rd_val[FLG_VM0] = vm_q[0];
                rd_val[FLG_VM1] = vm_q[1];
                rd_val[FLG_MV] = mv_q;
                rd_val[FLG_Z] = z_q;
                rd_val[FLG_V] = v_q;
                rd_val[FLG_N] = n_q;
            end
            OFS_X0: rd_val[DW-1:0] = x_operand_reg_q[0];
            OFS_X1: rd_val[DW-1:0] = x_operand_reg_q[1];
            OFS_Y0: rd_val[DW-1:0] = y_operand_reg_q[0];
            OFS_Y1: rd_val[DW-1:0] = y_operand_reg_q[1];
            OFS_P_LO: rd_val = p_q[31:0];
            OFS_P_HI: rd_val[PW-33:0] = p_q[PW-1:32];
            OFS_MA0_LO: rd_val = mac_accumulator_q[0][31:0];
            OFS_MA0_HI: rd_val[MW-33:0] = mac_accumulator_q[0][MW-1:32];
            OFS_MA1_LO: rd_val = mac_accumulator_q[1][31:0];
            OFS_MA1_HI: rd_val[MW-33:0] = mac_accumulator_q[1][MW-1:32];
            OFS_A0: rd_val[DW-1:0] = general_accumulator_q[0];
            OFS_A1: rd_val[DW-1:0] = general_accumulator_q[1];
            OFS_A2: rd_val[DW-1:0] = general_accumulator_q[2];
            OFS_A3: rd_val[DW-1:0] = general_accumulator_q[3];
            OFS_PTR0, OFS_PTR1, OFS_PTR3: begin
                for (int i = 0; i < 3; i++) begin
                    if (paddr == ptr_ofs[i]) begin
                        rd_val[AW-1:0] = ptr_q[i];
                        rd_val[PTR_STEP_LSB+AW-1:PTR_STEP_LSB] = step_q[i];
                    end
                end
            end
            default: rd_err = 1'b1;
        endcase
    end

    // Read data and error are captured in the setup cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_val;
            pslverr_q <= rd_err;
        end
    end

    // =========================================================
    // Operand registers: instruction load wins over software
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            x_operand_reg_q <= '{RST_DATA, RST_DATA};
        end else if (two_mv) begin
            x_operand_reg_q[instr_dest[0]] <= xmem_rdata;
        end else if (one_mv && instr_dest[2] && !instr_dest[1]) begin
            x_operand_reg_q[instr_dest[0]] <= mv_val;
        end else if (apb_wr && paddr == OFS_X0) begin
            x_operand_reg_q[0] <= pwdata[DW-1:0];
        end else if (apb_wr && paddr == OFS_X1) begin
            x_operand_reg_q[1] <= pwdata[DW-1:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            y_operand_reg_q <= '{RST_DATA, RST_DATA};
        end else if (two_mv) begin
            y_operand_reg_q[instr_dest[1]] <= ymem_rdata;
        end else if (one_mv && dest_y) begin
            y_operand_reg_q[instr_dest[0]] <= mv_val;
        end else if (apb_wr && paddr == OFS_Y0) begin
            y_operand_reg_q[0] <= pwdata[DW-1:0];
        end else if (apb_wr && paddr == OFS_Y1) begin
            y_operand_reg_q[1] <= pwdata[DW-1:0];
        end
    end

    // =========================================================
    // Product and multiplier accumulators
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            p_q <= RST_PROD;
        end else if (instr_valid) begin
            p_q <= prod;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mac_accumulator_q <= '{RST_MAC, RST_MAC};
        end else if (is_msb) begin
            mac_accumulator_q[instr_mac] <= diff[MW-1:0];
        end
    end

    // =========================================================
    // Guard flags
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vm_q <= 2'h0;
        end else if (is_msb) begin
            vm_q[instr_mac] <= vm_d;
        end
    end

    // Hardware set wins over software clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mv_q <= 1'b0;
        end else begin
            mv_q <= (is_msb && mv_ovf) || (mv_q && !mv_clr);
        end
    end

    // =========================================================
    // General accumulators and load flags
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            general_accumulator_q <= '{RST_DATA, RST_DATA, RST_DATA, RST_DATA};
        end else if (one_mv && dest_a) begin
            general_accumulator_q[instr_dest[1:0]] <= mv_val;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            z_q <= 1'b0;
            v_q <= 1'b0;
            n_q <= 1'b0;
        end else if (one_mv && dest_a) begin
            z_q <= (mv_val == RST_DATA);
            v_q <= mv_vflag;
            n_q <= mv_val[DW-1];
        end
    end

    assign guard_overflow_flag = vm_q;
    assign sticky_guard_overflow = mv_q;
    assign zero_flag = z_q;
    assign overflow_flag = v_q;
    assign negative_flag = n_q;

    // =========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_msb_issue;
        instr_valid && instr_op == multiply_subtract_op;
    endsequence

    sequence s_acc_load;
        instr_valid && instr_move == mv_one && !instr_dest[2];
    endsequence

    a_mac_subtract: assert property (s_msb_issue |=>
        mac_accumulator_q[$past(instr_mac)] ==
        $past(ma_sel) - {{4{$past(p_q[PW-1])}}, $past(p_q)})
        else $error("accumulator not reduced by product");

    a_prod_load: assert property (instr_valid |=>
        $signed(p_q) == $signed($past(x_sel)) * $signed($past(y_sel)))
        else $error("product not old x times old y");

    a_x_fetch: assert property (instr_valid && instr_move == mv_two |=>
        x_operand_reg_q[$past(instr_dest[0])] == $past(xmem_rdata)
        && y_operand_reg_q[$past(instr_dest[1])] == $past(ymem_rdata))
        else $error("operand fetch lost");

    a_ptr_step: assert property (instr_valid && instr_move == mv_two |=>
        ymem_addr == $past(ptr_q[2]) + $past(step_q[2]))
        else $error("y pointer did not step");

    a_vm_value: assert property (s_msb_issue ##1 1 |->
        vm_q[$past(instr_mac)] ==
        !(mac_accumulator_q[$past(instr_mac)][MW-1:GB_LSB] == 5'h00
        || mac_accumulator_q[$past(instr_mac)][MW-1:GB_LSB] == 5'h1F))
        else $error("guard flag disagrees with result");

    a_mv_sticky: assert property (mv_q && !mv_clr |=> mv_q)
        else $error("sticky guard flag dropped");

    a_vm_other: assert property (s_msb_issue and !instr_mac |=>
        $stable(vm_q[1]))
        else $error("untargeted guard flag changed");

    a_plain_mul: assert property (instr_valid && instr_op == multiply_op
        && instr_move == mv_none && !mv_clr |=>
        $stable({vm_q, mv_q, z_q, v_q, n_q}) && $stable(mac_accumulator_q[0])
        && $stable(mac_accumulator_q[1]))
        else $error("plain multiply touched flags");

    a_shift_right: assert property (s_acc_load
        and instr_src == accum_high_shift_right |=>
        general_accumulator_q[$past(instr_dest[1:0])] ==
        {$past(src_hi[DW-1]), $past(src_hi[DW-1:1])})
        else $error("right shift move wrong");

    a_shift_left: assert property (s_acc_load
        and instr_src == accum_high_shift_left |=>
        general_accumulator_q[$past(instr_dest[1:0])] ==
        {$past(src_hi[DW-2:0]), 1'b0})
        else $error("left shift move wrong");

    a_zero_neg: assert property (s_acc_load |=>
        z_q == (general_accumulator_q[$past(instr_dest[1:0])] == 24'h000000)
        && n_q == general_accumulator_q[$past(instr_dest[1:0])][DW-1])
        else $error("zero or negative flag wrong");

    a_load_ovf: assert property (s_acc_load
        and instr_src == src_memory |=> !v_q)
        else $error("memory load flagged overflow");

endmodule
`default_nettype wire

// ### rtl/dmsd_pkg.sv
// Constants and types of the multiply-subtract datapath slice
// What this block does
// - Subtract product from chosen accumulator, store back
// - Every multiply loads X times Y into product
// - Two-load forms fetch X and Y operands
// - X via pointer 0/1, Y via pointer 3
// - Guard overflow flag follows result spill
// - Sticky guard flag sets on overflow of the full 52-bit subtract result
// - One guard flag per accumulator, targeted only
// - Plain multiply touches only the product
// - One-move loads from memory or accumulator high
// - Right-shift option: bits 47:24 shifted right
// - Left-shift option: bits 47:24 shifted left
// - Zero flag from value loaded into accumulator
// - Overflow flag from load into accumulator
// - Negative flag from value loaded into accumulator
// - General accumulators are 24 bits wide
package dmsd_pkg;

    // =========================================================
    // Widths
    localparam int DW = 24;
    localparam int PW = 48;
    localparam int MW = 52;
    localparam int AW = 15;
    localparam int GB_LSB = 47;
    localparam int HI_LSB = 24;

    // =========================================================
    // Register offsets
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_X0 = 8'h04;
    localparam logic [7:0] OFS_X1 = 8'h08;
    localparam logic [7:0] OFS_Y0 = 8'h0C;
    localparam logic [7:0] OFS_Y1 = 8'h10;
    localparam logic [7:0] OFS_P_LO = 8'h14;
    localparam logic [7:0] OFS_P_HI = 8'h18;
    localparam logic [7:0] OFS_MA0_LO = 8'h1C;
    localparam logic [7:0] OFS_MA0_HI = 8'h20;
    localparam logic [7:0] OFS_MA1_LO = 8'h24;
    localparam logic [7:0] OFS_MA1_HI = 8'h28;
    localparam logic [7:0] OFS_A0 = 8'h2C;
    localparam logic [7:0] OFS_A1 = 8'h30;
    localparam logic [7:0] OFS_A2 = 8'h34;
    localparam logic [7:0] OFS_A3 = 8'h38;
    localparam logic [7:0] OFS_PTR0 = 8'h3C;
    localparam logic [7:0] OFS_PTR1 = 8'h40;
    localparam logic [7:0] OFS_PTR3 = 8'h44;

    // =========================================================
    // Field positions
    localparam int FLG_VM0 = 0;
    localparam int FLG_VM1 = 1;
    localparam int FLG_MV = 2;
    localparam int FLG_Z = 3;
    localparam int FLG_V = 4;
    localparam int FLG_N = 5;
    localparam int PTR_STEP_LSB = 16;

    // =========================================================
    // Reset values
    localparam logic [DW-1:0] RST_DATA = 24'h000000;
    localparam logic [PW-1:0] RST_PROD = 48'h000000000000;
    localparam logic [MW-1:0] RST_MAC = 52'h0000000000000;
    localparam logic [AW-1:0] RST_PTR = 15'h0000;
    localparam logic [AW-1:0] RST_STEP = 15'h0001;

    // =========================================================
    // Instruction fields
    typedef enum logic {multiply_subtract_op, multiply_op} dmsd_op_t;
    typedef enum logic [1:0] {mv_none, mv_one, mv_two} dmsd_move_t;
    typedef enum logic [1:0] {
        src_accum_high,
        accum_high_shift_right,
        accum_high_shift_left,
        src_memory
    } dmsd_src_t;

endpackage

// ### rtl/dmsd_ptr.sv
// Pointer register with post-step
`timescale 1ns/1ns
`default_nettype none
module dmsd_ptr import dmsd_pkg::*; #(
    parameter logic [AW-1:0] RST_ADDR = RST_PTR
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Software load
    input wire logic wr,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [AW-1:0] wr_step,
    // Post-step on use
    input wire logic adv,
    // State
    output logic [AW-1:0] addr_q,
    output logic [AW-1:0] step_q
);

    // Use by an instruction wins over a software load
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            addr_q <= RST_ADDR;
        end else if (adv) begin
            addr_q <= addr_q + step_q;
        end else if (wr) begin
            addr_q <= wr_addr;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            step_q <= RST_STEP;
        end else if (wr) begin
            step_q <= wr_step;
        end
    end

endmodule
`default_nettype wire

// ### dv/dmsd_mem_model.sv
// Behavioural X and Y data memories that answer in the same cycle
`timescale 1ns/1ns
`default_nettype none
module dmsd_mem_model import dmsd_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // X memory
    input wire logic [AW-1:0] x_addr,
    input wire logic x_re,
    output logic [DW-1:0] x_rdata,
    // Y memory
    input wire logic [AW-1:0] y_addr,
    input wire logic y_re,
    output logic [DW-1:0] y_rdata
);
    logic [DW-1:0] x_last_q;
    logic [DW-1:0] y_last_q;
    // Unread cycles show a toggling pattern, never a stale word
    assign x_rdata = x_re ? {x_addr[11:0], ~x_addr[11:0]} : ~x_last_q;
    assign y_rdata = y_re ? {~y_addr[11:0], y_addr[11:0]} : ~y_last_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            x_last_q <= 24'h000000;
            y_last_q <= 24'h000000;
        end else begin
            x_last_q <= x_rdata;
            y_last_q <= y_rdata;
        end
    end
endmodule
`default_nettype wire

// ### dv/tb_dsp_multiply_subtract_datapath.sv
// Self-checking bench for the multiply-subtract datapath
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_dsp_multiply_subtract_datapath import dmsd_pkg::*;;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic instr_valid, instr_mac, instr_x, instr_y, instr_xptr, instr_src_mac;
    dmsd_op_t instr_op;
    dmsd_move_t instr_move;
    logic [2:0] instr_dest;
    dmsd_src_t instr_src;
    logic [AW-1:0] xmem_addr, ymem_addr, cap_xa, cap_ya;
    logic xmem_re, ymem_re;
    logic [1:0] cap_re, guard_overflow_flag;
    logic [DW-1:0] xmem_rdata, ymem_rdata;
    logic sticky_guard_overflow, zero_flag, overflow_flag, negative_flag;
    int fails, tests_run;

    dmsd_datapath dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_move(instr_move), .instr_mac(instr_mac), .instr_x(instr_x), .instr_y(instr_y),
        .instr_xptr(instr_xptr), .instr_dest(instr_dest), .instr_src(instr_src),
        .instr_src_mac(instr_src_mac), .xmem_addr(xmem_addr), .xmem_re(xmem_re),
        .xmem_rdata(xmem_rdata), .ymem_addr(ymem_addr), .ymem_re(ymem_re),
        .ymem_rdata(ymem_rdata), .guard_overflow_flag(guard_overflow_flag),
        .sticky_guard_overflow(sticky_guard_overflow), .zero_flag(zero_flag),
        .overflow_flag(overflow_flag), .negative_flag(negative_flag));
    dmsd_mem_model mem_u (.clk(clk), .nrst(nrst), .x_addr(xmem_addr), .x_re(xmem_re),
        .x_rdata(xmem_rdata), .y_addr(ymem_addr), .y_re(ymem_re), .y_rdata(ymem_rdata));

    // =========================================================
    // Helpers
    function automatic logic [47:0] mul(input logic [23:0] a, input logic [23:0] b);
        logic signed [47:0] r;
        r = $signed(a) * $signed(b);
        return r;
    endfunction
    function automatic logic [23:0] xd(input logic [14:0] a);
        return {a[11:0], ~a[11:0]};
    endfunction
    function automatic logic [23:0] yd(input logic [14:0] a);
        return {~a[11:0], a[11:0]};
    endfunction
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic reset_dut;
        nrst <= 1'b0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h00000000, r, e);
        `CHK(nm, ex, r)
    endtask
    task automatic issue(input dmsd_op_t op, input dmsd_move_t mv, input logic mac,
        input logic xp, input logic [2:0] dst, input dmsd_src_t src, input logic smac);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_move <= mv;
        instr_mac <= mac;
        instr_x <= mac;
        instr_y <= mac;
        instr_xptr <= xp;
        instr_dest <= dst;
        instr_src <= src;
        instr_src_mac <= smac;
        #1;
        cap_xa = xmem_addr;
        cap_ya = ymem_addr;
        cap_re = {xmem_re, ymem_re};
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    // =========================================================
    // Scenarios
    task automatic t_guard;
        logic [MW-1:0] ma, nx, p;
        logic mv;
        logic [5:0] fl;
        reset_dut;
        wr(OFS_X1, 32'h00800000);
        wr(OFS_Y1, 32'h00800000);
        ma = '0;
        p = '0;
        mv = 1'b0;
        for (int k = 0; k < 40; k++) begin
            issue(multiply_subtract_op, mv_none, 1'b1, 1'b0, 3'h0, src_memory, 1'b0);
            nx = ma - p;
            mv = mv | (ma[51] & ~p[51] & ~nx[51]);
            ma = nx;
            p = 52'h0400000000000;
            `CHK("vm1", ~(&ma[51:47] | ~|ma[51:47]), guard_overflow_flag[1])
            `CHK("vm0", 1'b0, guard_overflow_flag[0])
            `CHK("mv", mv, sticky_guard_overflow)
        end
        rd_chk("ma1_lo", OFS_MA1_LO, ma[31:0]);
        rd_chk("ma1_hi", OFS_MA1_HI, {12'h000, ma[51:32]});
        rd_chk("p_hi", OFS_P_HI, 32'h00004000);
        wr(OFS_FLAGS, 32'h00000004);
        rd_chk("flags_mv", OFS_FLAGS, {30'h00000000, ~(&ma[51:47] | ~|ma[51:47]), 1'b0});
        fl = {guard_overflow_flag, sticky_guard_overflow, zero_flag, overflow_flag, negative_flag};
        issue(multiply_op, mv_none, 1'b0, 1'b0, 3'h0, src_memory, 1'b0);
        `CHK("flags", fl, {guard_overflow_flag, sticky_guard_overflow, zero_flag,
            overflow_flag, negative_flag})
        rd_chk("p_hi0", OFS_P_HI, 32'h00000000);
        issue(multiply_op, mv_one, 1'b0, 1'b0, 3'h0, src_accum_high, 1'b1);
        rd_chk("a0", OFS_A0, {8'h00, ma[47:24]});
        `CHK("v", ~(&ma[51:47] | ~|ma[51:47]), overflow_flag)
        `CHK("n", ma[47], negative_flag)
        issue(multiply_op, mv_one, 1'b0, 1'b0, 3'h1, src_memory, 1'b0);
        rd_chk("a1", OFS_A1, {8'h00, xd(15'h0000)});
        `CHK("v0", 1'b0, overflow_flag)
        `CHK("z0", 1'b0, zero_flag)
        $display("guard test done");
    endtask

    task automatic t_move;
        dmsd_src_t s[4] = '{src_accum_high, accum_high_shift_right, accum_high_shift_left,
            src_accum_high};
        logic [23:0] e[4] = '{24'hFFFF00, 24'hFFFF80, 24'hFFFE00, 24'h000000};
        reset_dut;
        wr(OFS_X0, 32'h00400000);
        wr(OFS_Y0, 32'h00000400);
        repeat (2) issue(multiply_subtract_op, mv_none, 1'b0, 1'b0, 3'h0, src_memory, 1'b0);
        for (int i = 0; i < 4; i++) begin
            issue(multiply_op, mv_one, 1'b0, 1'b0, 3'(i), s[i], i == 3);
            rd_chk("acc", OFS_A0 + 8'(4 * i), {8'h00, e[i]});
            `CHK("z", i == 3, zero_flag)
            `CHK("n", e[i][23], negative_flag)
            `CHK("v", 1'b0, overflow_flag)
        end
        issue(multiply_op, mv_one, 1'b0, 1'b0, 3'h5, src_memory, 1'b0);
        `CHK("xa", 15'h0000, cap_xa)
        rd_chk("x1", OFS_X1, {8'h00, xd(15'h0000)});
        rd_chk("ptr0", OFS_PTR0, 32'h00010001);
        issue(multiply_op, mv_one, 1'b0, 1'b0, 3'h6, src_memory, 1'b0);
        `CHK("ya", {15'h0000, 2'b01}, {cap_ya, cap_re})
        rd_chk("y0", OFS_Y0, {8'h00, yd(15'h0000)});
        $display("move test done");
    endtask

    task automatic t_two;
        logic [31:0] r;
        logic e;
        logic [47:0] p;
        reset_dut;
        rd_chk("ptr1_rst", OFS_PTR1, 32'h00010000);
        apb(1'b0, 8'hFC, 32'h00000000, r, e);
        `CHK("unmapped", 33'h100000000, {e, r})
        wr(OFS_PTR0, 32'h00020005);
        wr(OFS_PTR1, 32'h00010014);
        wr(OFS_PTR3, 32'h00030009);
        wr(OFS_X0, 32'h00000003);
        wr(OFS_Y0, 32'h00FFFFFE);
        issue(multiply_subtract_op, mv_two, 1'b0, 1'b0, 3'h0, src_memory, 1'b0);
        `CHK("addr1", {15'h0005, 15'h0009, 2'b11}, {cap_xa, cap_ya, cap_re})
        issue(multiply_subtract_op, mv_two, 1'b0, 1'b1, 3'h0, src_memory, 1'b0);
        `CHK("addr2", {15'h0014, 15'h000C, 2'b11}, {cap_xa, cap_ya, cap_re})
        p = mul(xd(15'h0005), yd(15'h0009));
        rd_chk("p_lo", OFS_P_LO, p[31:0]);
        rd_chk("p_hi", OFS_P_HI, {16'h0000, p[47:32]});
        rd_chk("ma0", OFS_MA0_LO, 32'h00000006);
        rd_chk("x0", OFS_X0, {8'h00, xd(15'h0014)});
        rd_chk("y0", OFS_Y0, {8'h00, yd(15'h000C)});
        rd_chk("ptr3", OFS_PTR3, 32'h0003000F);
        $display("two load test done");
    endtask

    // =========================================================
    // Clock, watchdog and main sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        fails++;
        end_sim;
    end
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        {instr_valid, instr_mac, instr_x, instr_y, instr_xptr, instr_dest, instr_src_mac} = '0;
        instr_op = multiply_op;
        instr_move = mv_none;
        instr_src = src_memory;
        fails = 0;
        tests_run = 0;
        t_two;
        t_move;
        t_guard;
        end_sim;
    end
endmodule
`default_nettype wire
